// [rtl/dimp_pkg.sv]
// package of constants for the mode programming and write path block
// assumes a 4-bank device, 13 address pins and a 16-bit data bus
package dimp_pkg;

  // ==========================================================
  // pin widths
  localparam int ADDR_W = 13;
  localparam int BANK_W = 2;
  localparam int DATA_W = 16;
  localparam int LANE_N = 2;
  localparam int COL_W  = 9;

  // ==========================================================
  // command codes as {cs_n, ras_n, cas_n, we_n}
  localparam logic [3:0] CMD_MODE_WRITE = 4'h0;
  localparam logic [3:0] CMD_REFRESH    = 4'h1;
  localparam logic [3:0] CMD_PRECHARGE  = 4'h2;
  localparam logic [3:0] CMD_WRITE      = 4'h4;
  localparam logic [3:0] CMD_READ       = 4'h5;

  // ==========================================================
  // mode register field positions
  localparam int MR_BL_LSB   = 0;
  localparam int MR_ILV_BIT  = 3;
  localparam int MR_RL_LSB   = 4;
  localparam int MR_TEST_BIT = 7;
  localparam int LOOP_RESET_BIT = 8;
  localparam int EMR_DLL_BIT = 0;
  localparam int EMR_DS_LO   = 1;
  localparam int EMR_DS_HI   = 6;
  localparam int EXT_SEL_BIT = 0;

  // burst length codes
  localparam logic [2:0] BL_CODE_2 = 3'h1;
  localparam logic [2:0] BL_CODE_4 = 3'h2;
  localparam logic [2:0] BL_CODE_8 = 3'h3;

  // ==========================================================
  // reset values and timing counts
  localparam logic [ADDR_W-1:0] MODE_RST = 13'h0000;
  localparam int DLL_LOCK_CYCLES = 200;
  localparam int MIN_REFRESH_N   = 2;

  typedef enum logic [0:0] {
    DIMP_WP_IDLE,
    DIMP_WP_BURST
  } dimp_wp_e;

endpackage

// [rtl/dimp_sync.sv]
// two flip-flop level synchroniser, one bit per lane
// assumes each bit is a level that is steady for several dst clocks
`timescale 1ns/10ps
module dimp_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk_dst,
  input  wire logic [WIDTH-1:0] d_async,
  output logic      [WIDTH-1:0] q_sync
);

  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] nxt_meta;

  // ==========================================================
  // stage one feeds stage two only
  always_comb begin
    nxt_meta = d_async;
  end

  always_ff @(posedge clk_dst) begin
    meta_ff <= nxt_meta;
    q_sync  <= meta_ff;
  end

endmodule

// [rtl/dimp_dll_lock.sv]
// lock counter for the delay-locked loop, on the memory clock
// assumes restart is a one-cycle pulse from the command decoder
`timescale 1ns/10ps
module dimp_dll_lock #(
  parameter int LOCK_CYC = dimp_pkg::DLL_LOCK_CYCLES
) (
  input  wire logic mem_ck,
  input  wire logic link_rst,
  input  wire logic restart,
  input  wire logic enable,
  output logic      locked
);
  import dimp_pkg::*;

  logic [8:0] cnt_ff;
  logic [8:0] nxt_cnt;
  logic       locked_ff;
  logic       nxt_locked;
  logic [8:0] since_ff;

  localparam logic [8:0] LOCK_LAST = 9'(LOCK_CYC - 1);

  // ==========================================================
  // count clocks from the last restart while the loop is on
  always_comb begin
    nxt_cnt    = cnt_ff;
    nxt_locked = locked_ff;
    if (restart || !enable) begin
      nxt_cnt    = 9'h000;
      nxt_locked = 1'b0;
    end else if (!locked_ff) begin
      if (cnt_ff == LOCK_LAST) begin
        nxt_locked = 1'b1;
      end else begin
        nxt_cnt = cnt_ff + 9'h001;
      end
    end
  end

  always_ff @(posedge mem_ck) begin
    if (link_rst) begin
      cnt_ff    <= 9'h000;
      locked_ff <= 1'b0;
    end else begin
      cnt_ff    <= nxt_cnt;
      locked_ff <= nxt_locked;
    end
  end

  assign locked = locked_ff;

  // ==========================================================
  // helper: clocks since restart, saturating
  always_ff @(posedge mem_ck) begin
    if (link_rst || restart) begin
      since_ff <= 9'h000;
    end else if (since_ff != 9'h1ff) begin
      since_ff <= since_ff + 9'h001;
    end
  end

  AST_LOCK_CLEAR: assert property (
    @(posedge mem_ck) disable iff (link_rst)
    restart |=> !locked_ff [*2])
    else $error("loop lock not dropped on restart");

  AST_LOCK_TIME: assert property (
    @(posedge mem_ck) disable iff (link_rst)
    $rose(locked_ff) |-> (since_ff >= 9'(LOCK_CYC)))
    else $error("loop locked too early");

endmodule

// [rtl/dimp_top.sv]
// command decode, mode registers, loop lock and write data path
// assumes pins are sampled on mem_ck; status is read on clk
`timescale 1ns/10ps
// Behaviour
// - loop reset needs 200 clocks to lock
// - frequency change needs loop reset and 200 clocks
// - all strobes low with enable captures address
// - decode length, order, latency, test, reset
// - bank select 0 high means extended write
// - extended bit 0 switches the loop
// - extended bits 1 and 6 set drive
// - unmasked words before read are committed
// - masked words ignore the data strobe
// - byte mask acts in the same beat
module dimp_top #(
  parameter int LOCK_CYC = dimp_pkg::DLL_LOCK_CYCLES
) (
  input  wire logic                          clk,
  input  wire logic                          rst,
  input  wire logic                          mem_ck,
  input  wire logic                          cke,
  input  wire logic                          cs_n,
  input  wire logic                          ras_n,
  input  wire logic                          cas_n,
  input  wire logic                          we_n,
  input  wire logic [dimp_pkg::BANK_W-1:0]   bank_sel,
  input  wire logic [dimp_pkg::ADDR_W-1:0]   addr,
  input  wire logic [dimp_pkg::LANE_N-1:0]   byte_mask,
  input  wire logic [dimp_pkg::LANE_N-1:0]   dqs_in,
  input  wire logic [dimp_pkg::DATA_W-1:0]   dq_in,
  output logic                               arr_wr_valid,
  output logic      [dimp_pkg::BANK_W-1:0]   arr_wr_bank,
  output logic      [dimp_pkg::COL_W-1:0]    arr_wr_col,
  output logic      [dimp_pkg::DATA_W-1:0]   arr_wr_data,
  output logic      [dimp_pkg::LANE_N-1:0]   arr_wr_byte_en,
  output logic                               mode_valid,
  output logic      [2:0]                    burst_len_code,
  output logic                               burst_interleave,
  output logic      [2:0]                    read_latency_code,
  output logic                               test_mode,
  output logic                               ext_valid,
  output logic                               dll_enable,
  output logic      [1:0]                    drive_strength,
  output logic                               dll_locked,
  output logic                               init_done
);
  import dimp_pkg::*;

  // ==========================================================
  // link reset and command decode
  logic link_rst;
  logic cke_prev_ff;
  logic cmd_ok;
  logic [3:0] cmd;
  logic is_mrs;
  logic is_ext_mode_reg_write;
  logic is_wr;
  logic is_rd;
  logic is_ref;

  dimp_sync #(.WIDTH(1)) u_rst_sync (
    .clk_dst (mem_ck),
    .d_async (rst),
    .q_sync  (link_rst)
  );

  assign cmd     = {cs_n, ras_n, cas_n, we_n};
  assign cmd_ok  = cke && cke_prev_ff;
  assign is_mrs  = cmd_ok && (cmd == CMD_MODE_WRITE) && !bank_sel[EXT_SEL_BIT];
  assign is_ext_mode_reg_write = cmd_ok && (cmd == CMD_MODE_WRITE) && bank_sel[EXT_SEL_BIT];
  assign is_wr   = cmd_ok && (cmd == CMD_WRITE);
  assign is_rd   = cmd_ok && (cmd == CMD_READ);
  assign is_ref  = cmd_ok && (cmd == CMD_REFRESH);

  function automatic logic [3:0] burst_beats(input logic [2:0] code);
    case (code)
      BL_CODE_2: burst_beats = 4'h2;
      BL_CODE_4: burst_beats = 4'h4;
      BL_CODE_8: burst_beats = 4'h8;
      default:   burst_beats = 4'h0;
    endcase
  endfunction

  function automatic logic [2:0] beat_low(input logic [2:0] start,
                                          input logic [2:0] idx,
                                          input logic [3:0] bl,
                                          input logic       ilv);
    logic [2:0] m;
    logic [2:0] s;
    m = 3'(bl - 4'h1);
    s = ilv ? (start ^ idx) : 3'(start + idx);
    return (start & ~m) | (s & m);
  endfunction

  // ==========================================================
  // mode registers and init tracking, link side
  logic [ADDR_W-1:0] mode_word_ff;
  logic [ADDR_W-1:0] nxt_mode_word;
  logic [ADDR_W-1:0] ext_word_ff;
  logic [ADDR_W-1:0] nxt_ext_word;
  logic              mode_tgl_ff;
  logic              nxt_mode_tgl;
  logic              ext_tgl_ff;
  logic              nxt_ext_tgl;
  logic              mode_ok_ff;
  logic              nxt_mode_ok;
  logic [1:0]        ref_cnt_ff;
  logic [1:0]        nxt_ref_cnt;
  logic              init_ok_ff;
  logic              nxt_init_ok;
  logic              dll_restart;
  logic              link_locked;

  always_comb begin
    nxt_mode_word = mode_word_ff;
    nxt_ext_word  = ext_word_ff;
    nxt_mode_tgl  = mode_tgl_ff;
    nxt_ext_tgl   = ext_tgl_ff;
    nxt_mode_ok   = mode_ok_ff;
    nxt_ref_cnt   = ref_cnt_ff;
    nxt_init_ok   = init_ok_ff;
    if (is_mrs) begin
      nxt_mode_word = addr;
      nxt_mode_tgl  = ~mode_tgl_ff;
      nxt_mode_ok   = 1'b1;
      if (!addr[LOOP_RESET_BIT] && (ref_cnt_ff >= 2'(MIN_REFRESH_N))) begin
        nxt_init_ok = 1'b1;
      end
    end
    if (is_ext_mode_reg_write) begin
      nxt_ext_word = addr;
      nxt_ext_tgl  = ~ext_tgl_ff;
      nxt_ref_cnt  = 2'h0;
    end
    if (is_ref && (ref_cnt_ff != 2'h3)) begin
      nxt_ref_cnt = ref_cnt_ff + 2'h1;
    end
  end

  always_ff @(posedge mem_ck) begin
    if (link_rst) begin
      cke_prev_ff  <= 1'b0;
      mode_word_ff <= MODE_RST;
      ext_word_ff  <= MODE_RST;
      mode_tgl_ff  <= 1'b0;
      ext_tgl_ff   <= 1'b0;
      mode_ok_ff   <= 1'b0;
      ref_cnt_ff   <= 2'h0;
      init_ok_ff   <= 1'b0;
    end else begin
      cke_prev_ff  <= cke;
      mode_word_ff <= nxt_mode_word;
      ext_word_ff  <= nxt_ext_word;
      mode_tgl_ff  <= nxt_mode_tgl;
      ext_tgl_ff   <= nxt_ext_tgl;
      mode_ok_ff   <= nxt_mode_ok;
      ref_cnt_ff   <= nxt_ref_cnt;
      init_ok_ff   <= nxt_init_ok;
    end
  end

  // loop restarts on loop reset or on any extended write that leaves the loop on
  assign dll_restart = (is_mrs && addr[LOOP_RESET_BIT]) ||
                       (is_ext_mode_reg_write && !addr[EMR_DLL_BIT]);

  dimp_dll_lock #(.LOCK_CYC(LOCK_CYC)) u_dll_lock (
    .mem_ck   (mem_ck),
    .link_rst (link_rst),
    .restart  (dll_restart),
    .enable   (!ext_word_ff[EMR_DLL_BIT]),
    .locked   (link_locked)
  );

  // ==========================================================
  // write burst path, link side
  dimp_wp_e          wp_state_ff;
  dimp_wp_e          nxt_wp_state;
  logic [2:0]        beat_idx_ff;
  logic [2:0]        nxt_beat_idx;
  logic [3:0]        bl_ff;
  logic [3:0]        nxt_bl;
  logic [BANK_W-1:0] wr_bank_ff;
  logic [BANK_W-1:0] nxt_wr_bank;
  logic [COL_W-1:0]  wr_col_ff;
  logic [COL_W-1:0]  nxt_wr_col;
  logic              ilv_ff;
  logic              nxt_ilv;
  logic              nxt_arr_valid;
  logic [LANE_N-1:0] nxt_arr_be;
  logic [LANE_N-1:0] lane_en;
  logic [3:0]        cmd_bl;

  assign cmd_bl  = burst_beats(mode_word_ff[MR_BL_LSB +: 3]);
  // a masked lane ignores its strobe; mask acts in this beat
  assign lane_en = dqs_in & ~byte_mask;

  always_comb begin
    nxt_wp_state  = wp_state_ff;
    nxt_beat_idx  = beat_idx_ff;
    nxt_bl        = bl_ff;
    nxt_wr_bank   = wr_bank_ff;
    nxt_wr_col    = wr_col_ff;
    nxt_ilv       = ilv_ff;
    nxt_arr_valid = 1'b0;
    nxt_arr_be    = {LANE_N{1'b0}};
    case (wp_state_ff)
      DIMP_WP_IDLE: begin
      end
      DIMP_WP_BURST: begin
        // beat in the read cycle is dropped; earlier ones committed
        if (!is_rd && (lane_en != {LANE_N{1'b0}})) begin
          nxt_arr_valid = 1'b1;
          nxt_arr_be    = lane_en;
        end
        if (is_rd || (4'({1'b0, beat_idx_ff}) == bl_ff - 4'h1)) begin
          nxt_wp_state = DIMP_WP_IDLE;
        end else begin
          nxt_beat_idx = beat_idx_ff + 3'h1;
        end
      end
      default: begin
        nxt_wp_state = DIMP_WP_IDLE;
      end
    endcase
    // bursts run only once the mode register holds a valid length
    if (is_wr && mode_ok_ff && (cmd_bl != 4'h0)) begin
      nxt_wp_state = DIMP_WP_BURST;
      nxt_beat_idx = 3'h0;
      nxt_bl       = cmd_bl;
      nxt_wr_bank  = bank_sel;
      nxt_wr_col   = addr[COL_W-1:0];
      nxt_ilv      = mode_word_ff[MR_ILV_BIT];
    end
  end

  always_ff @(posedge mem_ck) begin
    if (link_rst) begin
      wp_state_ff    <= DIMP_WP_IDLE;
      beat_idx_ff    <= 3'h0;
      bl_ff          <= 4'h0;
      wr_bank_ff     <= {BANK_W{1'b0}};
      wr_col_ff      <= {COL_W{1'b0}};
      ilv_ff         <= 1'b0;
      arr_wr_valid   <= 1'b0;
      arr_wr_bank    <= {BANK_W{1'b0}};
      arr_wr_col     <= {COL_W{1'b0}};
      arr_wr_data    <= {DATA_W{1'b0}};
      arr_wr_byte_en <= {LANE_N{1'b0}};
    end else begin
      wp_state_ff    <= nxt_wp_state;
      beat_idx_ff    <= nxt_beat_idx;
      bl_ff          <= nxt_bl;
      wr_bank_ff     <= nxt_wr_bank;
      wr_col_ff      <= nxt_wr_col;
      ilv_ff         <= nxt_ilv;
      arr_wr_valid   <= nxt_arr_valid;
      arr_wr_bank    <= wr_bank_ff;
      arr_wr_col     <= {wr_col_ff[COL_W-1:3],
                         beat_low(wr_col_ff[2:0], beat_idx_ff, bl_ff, ilv_ff)};
      arr_wr_data    <= dq_in;
      arr_wr_byte_en <= nxt_arr_be;
    end
  end

  // ==========================================================
  // crossing to clk: toggles and levels via two flops
  logic [3:0] st_sync;
  logic       mode_tgl_seen_ff;
  logic       ext_tgl_seen_ff;

  dimp_sync #(.WIDTH(4)) u_stat_sync (
    .clk_dst (clk),
    .d_async ({init_ok_ff, link_locked, ext_tgl_ff, mode_tgl_ff}),
    .q_sync  (st_sync)
  );

  // mode words are quiet for two link clocks after a write
  always_ff @(posedge clk) begin
    if (rst) begin
      mode_tgl_seen_ff  <= 1'b0;
      ext_tgl_seen_ff   <= 1'b0;
      mode_valid        <= 1'b0;
      burst_len_code    <= 3'h0;
      burst_interleave  <= 1'b0;
      read_latency_code <= 3'h0;
      test_mode         <= 1'b0;
      ext_valid         <= 1'b0;
      dll_enable        <= 1'b0;
      drive_strength    <= 2'h0;
      dll_locked        <= 1'b0;
      init_done         <= 1'b0;
    end else begin
      mode_tgl_seen_ff <= st_sync[0];
      ext_tgl_seen_ff  <= st_sync[1];
      dll_locked       <= st_sync[2];
      init_done        <= st_sync[3];
      if (st_sync[0] != mode_tgl_seen_ff) begin
        mode_valid        <= 1'b1;
        burst_len_code    <= mode_word_ff[MR_BL_LSB +: 3];
        burst_interleave  <= mode_word_ff[MR_ILV_BIT];
        read_latency_code <= mode_word_ff[MR_RL_LSB +: 3];
        test_mode         <= mode_word_ff[MR_TEST_BIT];
      end
      if (st_sync[1] != ext_tgl_seen_ff) begin
        ext_valid      <= 1'b1;
        dll_enable     <= !ext_word_ff[EMR_DLL_BIT];
        drive_strength <= {ext_word_ff[EMR_DS_HI],
                           ext_word_ff[EMR_DS_LO]};
      end
    end
  end

  // ==========================================================
  // checks on the link side
  AST_MRS_CAPTURE: assert property (
    @(posedge mem_ck) disable iff (link_rst)
    is_mrs |=> (mode_word_ff == $past(addr)) && $stable(ext_word_ff))
    else $error("mode word not captured");

  AST_EXT_MODE_REG_WRITE_SEL: assert property (
    @(posedge mem_ck) disable iff (link_rst)
    is_ext_mode_reg_write |=> (ext_word_ff == $past(addr)) && $stable(mode_word_ff))
    else $error("extended write misrouted");

  AST_NO_CMD_LOW_CKE: assert property (
    @(posedge mem_ck) disable iff (link_rst)
    !cke |=> $stable(mode_word_ff) && $stable(ext_word_ff))
    else $error("mode write taken with clock enable low");

  AST_MASK_SAME_BEAT: assert property (
    @(posedge mem_ck) disable iff (link_rst)
    arr_wr_valid |-> ((arr_wr_byte_en & $past(byte_mask)) == 2'h0))
    else $error("masked byte committed");

  AST_DQS_IGNORED: assert property (
    @(posedge mem_ck) disable iff (link_rst)
    (wp_state_ff == DIMP_WP_BURST) && !is_rd && (byte_mask == 2'h3)
    |=> !arr_wr_valid)
    else $error("fully masked beat committed");

  AST_RD_STOP: assert property (
    @(posedge mem_ck) disable iff (link_rst)
    is_rd && !is_wr |=> !arr_wr_valid ##1 !arr_wr_valid)
    else $error("write data after interrupting read");

  AST_BEAT_COMMIT: assert property (
    @(posedge mem_ck) disable iff (link_rst)
    (wp_state_ff == DIMP_WP_BURST) && !is_rd && (lane_en != 2'h0)
    |=> arr_wr_valid && (arr_wr_data == $past(dq_in)))
    else $error("unmasked beat not committed");

  AST_INIT_DONE: assert property (
    @(posedge mem_ck) disable iff (link_rst)
    $rose(init_ok_ff) |-> $past(is_mrs) && !$past(addr[LOOP_RESET_BIT])
                          && ($past(ref_cnt_ff) >= 2'h2))
    else $error("init done without final mode write");

  AST_BURST_LEN: assert property (
    @(posedge mem_ck) disable iff (link_rst)
    (wp_state_ff == DIMP_WP_BURST) |-> (4'({1'b0, beat_idx_ff}) < bl_ff))
    else $error("burst ran past its length");

  COV_MRS: cover property (
    @(posedge mem_ck) disable iff (link_rst) is_mrs);
  COV_RD_INTERRUPT: cover property (
    @(posedge mem_ck) disable iff (link_rst)
    (wp_state_ff == DIMP_WP_BURST) && is_rd);
  COV_INIT: cover property (
    @(posedge mem_ck) disable iff (link_rst) $rose(init_ok_ff));
  COV_LOCK: cover property (
    @(posedge mem_ck) disable iff (link_rst) $rose(link_locked));

endmodule

// [tb/dimp_ctl.sv]
// controller model driving command, mask, strobe and data pins
// assumes mem_ck runs free from the bench; pins change on its fall
`timescale 1ns/10ps
module dimp_ctl
  import dimp_pkg::*;
(
  input  wire logic              mem_ck,
  output logic                   cke,
  output logic                   cs_n,
  output logic                   ras_n,
  output logic                   cas_n,
  output logic                   we_n,
  output logic      [BANK_W-1:0] bank_sel,
  output logic      [ADDR_W-1:0] addr,
  output logic      [LANE_N-1:0] byte_mask,
  output logic      [LANE_N-1:0] dqs_in,
  output logic      [DATA_W-1:0] dq_in
);
  // ==========================================================
  // pins at power application
  initial begin
    cke = 1'b0;
    {cs_n, ras_n, cas_n, we_n} = 4'h7;
    bank_sel = 2'h0;
    addr = 13'h0000;
    byte_mask = 2'h0;
    dqs_in = 2'h0;
    dq_in = 16'h0000;
  end

  // ==========================================================
  // one link cycle
  task automatic cyc(input logic [3:0] cmd, input logic [1:0] ba,
                     input logic [12:0] a, input logic [15:0] d,
                     input logic [1:0] m, input logic [1:0] s);
    @(negedge mem_ck);
    {cs_n, ras_n, cas_n, we_n} = cmd;
    bank_sel = ba;
    addr = a;
    byte_mask = m;
    dqs_in = s;
    // released data lines never keep the last word
    dq_in = (s != 2'h0) ? d : ~dq_in;
  endtask

  // no-op cycles alternate deselect and no-op and toggle the
  // don't-care pins so that a decoder leaking them would show
  task automatic idle(input int n);
    repeat (n) cyc({~cs_n, 3'h7}, ~bank_sel, ~addr, 16'h0000, ~byte_mask,
                   2'h0);
  endtask

  task automatic mode_wr(input logic [1:0] ba, input logic [12:0] a);
    cyc(CMD_MODE_WRITE, ba, a, 16'h0000, 2'h0, 2'h0);
    idle(2);
  endtask

  task automatic pre_all();
    cyc(CMD_PRECHARGE, 2'h0, 13'h0400, 16'h0000, 2'h0, 2'h0);
    idle(1);
  endtask

  task automatic power_up(input int stable_n);
    idle(stable_n);
    cke = 1'b1;
    idle(1);
  endtask
endmodule

// [tb/tb_dimp_top.sv]
// self-checking bench for the mode programming and write path block
// assumes the controller model dimp_ctl drives every link pin
`timescale 1ns/10ps
module tb_dimp_top;
  import dimp_pkg::*;
  localparam int LOCK = 8;
  localparam int TMO_CYC = 20000;
  logic              clk = 1'b0;
  logic              rst = 1'b1;
  logic              mem_ck = 1'b0;
  logic              cke, cs_n, ras_n, cas_n, we_n, arr_wr_valid;
  logic [BANK_W-1:0] bank_sel, arr_wr_bank;
  logic [ADDR_W-1:0] addr;
  logic [LANE_N-1:0] byte_mask, dqs_in, arr_wr_byte_en;
  logic [DATA_W-1:0] dq_in, arr_wr_data;
  logic [COL_W-1:0]  arr_wr_col;
  logic              mode_valid, burst_interleave, test_mode, ext_valid;
  logic              dll_enable, dll_locked, init_done;
  logic [2:0]        burst_len_code, read_latency_code;
  logic [1:0]        drive_strength;
  int                err_total = 0;
  int                tests_run = 0;
  int                tmo_cnt = 0;
  logic [31:0]       rnd_st = 32'hc070651e;
  logic [28:0]       exp_q[$];

  always #2 clk = ~clk;
  initial begin
    #5.3;
    forever #16 mem_ck = ~mem_ck;
  end

  dimp_top #(.LOCK_CYC(LOCK)) dimp_top_inst (
    .clk(clk), .rst(rst), .mem_ck(mem_ck), .cke(cke), .cs_n(cs_n),
    .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .bank_sel(bank_sel),
    .addr(addr), .byte_mask(byte_mask), .dqs_in(dqs_in), .dq_in(dq_in),
    .arr_wr_valid(arr_wr_valid), .arr_wr_bank(arr_wr_bank),
    .arr_wr_col(arr_wr_col), .arr_wr_data(arr_wr_data),
    .arr_wr_byte_en(arr_wr_byte_en), .mode_valid(mode_valid),
    .burst_len_code(burst_len_code), .burst_interleave(burst_interleave),
    .read_latency_code(read_latency_code), .test_mode(test_mode),
    .ext_valid(ext_valid), .dll_enable(dll_enable),
    .drive_strength(drive_strength), .dll_locked(dll_locked),
    .init_done(init_done));
  dimp_ctl dimp_ctl_inst (
    .mem_ck(mem_ck), .cke(cke), .cs_n(cs_n), .ras_n(ras_n),
    .cas_n(cas_n), .we_n(we_n), .bank_sel(bank_sel), .addr(addr),
    .byte_mask(byte_mask), .dqs_in(dqs_in), .dq_in(dq_in));

  // ==========================================================
  // helpers
  function automatic logic [31:0] rnd();
    rnd_st = rnd_st ^ (rnd_st << 13);
    rnd_st = rnd_st ^ (rnd_st >> 17);
    rnd_st = rnd_st ^ (rnd_st << 5);
    return rnd_st;
  endfunction
  function automatic logic [15:0] mode_now();
    return {7'h0, mode_valid, burst_len_code, burst_interleave,
            read_latency_code, test_mode};
  endfunction
  function automatic logic [15:0] ext_now();
    return {12'h0, ext_valid, dll_enable, drive_strength};
  endfunction
  task automatic chk(input string name, input logic [15:0] exp,
                     input logic [15:0] got);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value %0s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic chk_word(input logic [28:0] exp, input logic [28:0] got);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value array word expected %h seen %h", exp, got);
    end
  endtask
  task automatic done(input string name);
    $display("test %0s finished", name);
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // ==========================================================
  // committed words against the reference queue
  always @(negedge mem_ck) begin
    if (arr_wr_valid === 1'b1) begin
      if (exp_q.size() == 0) begin
        chk("unexpected commit", 16'h0, {15'h0, arr_wr_valid});
      end else begin
        chk_word(exp_q.pop_front(), {arr_wr_bank, arr_wr_col, arr_wr_data,
                 arr_wr_byte_en});
      end
    end
  end

  always @(posedge clk) begin
    tmo_cnt <= tmo_cnt + 1;
    if (tmo_cnt == TMO_CYC) begin
      err_total++;
      end_of_test();
    end
  end

  // write burst, optionally cut by a read at beat rd_at
  task automatic burst(input logic [1:0] ba, input logic [8:0] col,
                       input int bl, input logic ilv, input int rd_at);
    logic [15:0] d;
    logic [1:0]  mk;
    logic [1:0]  s;
    logic [8:0]  c;
    logic [8:0]  lo;
    lo = 9'(bl - 1);
    dimp_ctl_inst.cyc(CMD_WRITE, ba, {4'h0, col}, 16'h0, 2'h0, 2'h0);
    for (int i = 0; i < bl; i++) begin
      d = 16'(rnd());
      mk = 2'(rnd());
      s = 2'h3;
      if (rd_at > 0 && i >= rd_at - 1) mk = 2'h3;
      if (rd_at > 0 && i >= rd_at) s = 2'h0;
      c = ilv ? ((col ^ 9'(i)) & lo) : (9'(col + 9'(i)) & lo);
      c = c | (col & ~lo);
      // a fully masked beat commits nothing
      if ((rd_at == 0 || i < rd_at - 1) && mk != 2'h3) begin
        exp_q.push_back({ba, c, d, ~mk});
      end
      dimp_ctl_inst.cyc((i + 1 == rd_at) ? CMD_READ : 4'h7, ba,
                        {4'h0, col}, d, mk, s);
    end
    dimp_ctl_inst.idle(3);
    chk("pending words", 16'h0, 16'(exp_q.size()));
  endtask

  // ==========================================================
  // main sequence
  initial begin : main_seq
    logic [12:0] a;
    repeat (16) @(posedge mem_ck);
    @(negedge clk);
    rst = 1'b0;
    dimp_ctl_inst.power_up(6);
    chk("mode_valid", 16'h0, {15'h0, mode_valid});
    dimp_ctl_inst.cyc(CMD_WRITE, 2'h0, 13'h0004, 16'ha5a5, 2'h0, 2'h3);
    dimp_ctl_inst.idle(6);
    done("power up");
    dimp_ctl_inst.pre_all();
    dimp_ctl_inst.mode_wr(2'h1, 13'h0042);
    dimp_ctl_inst.mode_wr(2'h0, 13'h0122);
    chk("dll_locked", 16'h0, {15'h0, dll_locked});
    dimp_ctl_inst.pre_all();
    repeat (2) dimp_ctl_inst.cyc(CMD_REFRESH, 2'h0, 13'h0, 16'h0, 2'h0,
                                 2'h0);
    dimp_ctl_inst.mode_wr(2'h0, 13'h0022);
    dimp_ctl_inst.idle(8);
    chk("dll_locked", 16'h1, {15'h0, dll_locked});
    chk("init_done", 16'h1, {15'h0, init_done});
    chk("ext fields", 16'h000f, ext_now());
    chk("mode fields", 16'h0144, mode_now());
    done("init");
    dimp_ctl_inst.mode_wr(2'h0, 13'h0122);
    dimp_ctl_inst.idle(5);
    chk("dll_locked", 16'h0, {15'h0, dll_locked});
    dimp_ctl_inst.idle(5);
    chk("dll_locked", 16'h1, {15'h0, dll_locked});
    done("loop reset");
    for (int i = 3; i >= 0; i--) begin
      a = {6'h0, i[1], 4'h0, i[0], i == 3};
      dimp_ctl_inst.mode_wr(2'h1, a);
      dimp_ctl_inst.idle(4);
      chk("ext fields", {13'h1, i != 3, 2'(i)}, ext_now());
      if (i == 3) chk("dll_locked", 16'h0, {15'h0, dll_locked});
    end
    chk("mode fields", 16'h0144, mode_now());
    @(negedge mem_ck) dimp_ctl_inst.cke = 1'b0;
    dimp_ctl_inst.mode_wr(2'h0, 13'h0033);
    dimp_ctl_inst.cke = 1'b1;
    dimp_ctl_inst.idle(2);
    chk("mode fields", 16'h0144, mode_now());
    done("extended and refusal");
    for (int code = 1; code <= 3; code++) begin
      for (int i = 0; i < 2; i++) begin
        a = {6'h0, 3'(rnd()), i[0], 3'(code)};
        dimp_ctl_inst.pre_all();
        dimp_ctl_inst.mode_wr(2'h0, a);
        chk("mode fields", {8'h1, a[2:0], a[3], a[6:4], 1'b0},
            mode_now());
        burst(2'(rnd()), 9'(rnd()), 2 << (code - 1), i[0], 0);
      end
    end
    done("bursts");
    // mode register still holds interleaved length 8 here
    burst(2'h2, 9'h00e, 8, 1'b1, 2);
    dimp_ctl_inst.pre_all();
    dimp_ctl_inst.mode_wr(2'h0, 13'h0033);
    chk("mode fields", 16'h0166, mode_now());
    burst(2'h1, 9'h005, 8, 1'b0, 3);
    done("interrupting read");
    end_of_test();
  end
endmodule
